// >>> verilog/ir_counter_timer_capture.sv
`timescale 1ns/10ps
`include "ir_timer_consts.svh"

module ir_counter_timer_capture (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // axi4-lite write address
  input  wire logic                      s_axi_awvalid,
  output wire logic                      s_axi_awready,
  input  wire ir_timer_pkg::axi_addr_t   s_axi_aw,
  // axi4-lite write data
  input  wire logic                      s_axi_wvalid,
  output wire logic                      s_axi_wready,
  input  wire ir_timer_pkg::axi_wdata_t  s_axi_w,
  // axi4-lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // axi4-lite read address
  input  wire logic                      s_axi_arvalid,
  output wire logic                      s_axi_arready,
  input  wire ir_timer_pkg::axi_addr_t   s_axi_ar,
  // axi4-lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // pins
  input  wire logic                      port3_comparator_input_a,
  input  wire logic                      port3_comparator_input_b,
  input  wire logic                      port2_bit0_edge_input,
  output logic                           port3_byte_timer_output,
  output logic                           port3_word_timer_output,
  output logic                           port3_combined_timer_output,
  // interrupt
  output wire logic                      irq
);
  import ir_timer_pkg::*;

  // bus holding registers
  logic       aw_full_q;
  logic       w_full_q;
  axi_addr_t  aw_q;
  axi_wdata_t w_q;
  logic       wr_en;
  logic [3:0] wr_idx;
  logic       wr_ok;
  logic [7:0] wb;
  logic [3:0] rd_idx;
  logic       rd_ok;
  logic [7:0] rd_byte;

  // register state
  timer_ctrl_t byte_timer_control_q;
  timer_ctrl_t word_timer_control_q;
  logic [7:0]  common_timer_control_q;
  logic [7:0]  byte_timer_low_reload_q;
  logic [7:0]  byte_timer_high_reload_q;
  logic [7:0]  word_timer_low_reload_q;
  logic [7:0]  word_timer_high_reload_q;
  logic [7:0]  byte_timer_capture_low_level_q;
  logic [7:0]  byte_timer_capture_high_level_q;
  logic [15:0] word_cap_q;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_mask_q;
  logic [7:0]  irq_edge_q;

  // timer state
  logic [2:0]  div_q;
  logic        byte_tick;
  logic [7:0]  byte_cnt_q;
  logic        byte_out_q;
  logic        byte_armed_q;
  logic        byte_stop_pend_q;
  logic        byte_clr_pend_q;
  logic [15:0] word_cnt_q;
  logic        word_out_q;
  logic        word_armed_q;
  logic        word_stop_pend_q;
  logic        word_clr_pend_q;

  // edge detection
  logic      meas_in;
  logic      meas_prev_q;
  logic      cmp_a_prev_q;
  logic      cmp_b_prev_q;
  logic      meas_rise;
  logic      meas_fall;
  logic      meas_edge;
  edge_sel_t meas_sel;
  edge_sel_t cmp_sel;
  logic      cmp_a_ev;
  logic      cmp_b_ev;

  // events
  logic       byte_to_ev;
  logic       byte_cap_ev;
  logic       word_to_ev;
  logic       word_cap_ev;
  logic [7:0] ev_vec;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign wr_en         = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_idx        = aw_q.addr[5:2];
  assign wr_ok         = (aw_q.addr[7:6] == `ADDR_HI_ZERO) && (wr_idx <= `IDX_IRQ_EDGE) && (wr_idx != 4'h3);
  assign wb            = w_q.data[7:0];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_q         <= '0;
      w_q          <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_q      <= s_axi_aw;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_q      <= s_axi_w;
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_DECERR;
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one request at a time, answer one cycle later
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_ar.addr[5:2];
  assign rd_ok         = (s_axi_ar.addr[7:6] == `ADDR_HI_ZERO) && (rd_idx <= `IDX_IRQ_EDGE) && (rd_idx != 4'h3);

  // read mux, captured values returned as stored
  always_comb
  begin
    unique case (rd_idx)
      `IDX_BYTE_CTRL:   rd_byte = byte_timer_control_q;
      `IDX_COMMON_CTRL: rd_byte = common_timer_control_q;
      `IDX_WORD_CTRL:   rd_byte = word_timer_control_q;
      `IDX_BYTE_RLD_LO: rd_byte = byte_timer_low_reload_q;
      `IDX_BYTE_RLD_HI: rd_byte = byte_timer_high_reload_q;
      `IDX_WORD_RLD_LO: rd_byte = word_timer_low_reload_q;
      `IDX_WORD_RLD_HI: rd_byte = word_timer_high_reload_q;
      `IDX_WORD_CAP_LO: rd_byte = word_cap_q[7:0];
      `IDX_WORD_CAP_HI: rd_byte = word_cap_q[15:8];
      `IDX_BYTE_CAP_LO: rd_byte = byte_timer_capture_low_level_q;
      `IDX_BYTE_CAP_HI: rd_byte = byte_timer_capture_high_level_q;
      `IDX_IRQ_STATUS:  rd_byte = irq_status_q;
      `IDX_IRQ_MASK:    rd_byte = irq_mask_q;
      `IDX_IRQ_EDGE:    rd_byte = irq_edge_q;
      default:          rd_byte = `ZERO_8;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_ok ? rd_byte : `ZERO_8};
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // plain read/write registers, capture registers take no writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      common_timer_control_q   <= `RST_BYTE;
      byte_timer_low_reload_q  <= `RST_BYTE;
      byte_timer_high_reload_q <= `RST_BYTE;
      word_timer_low_reload_q  <= `RST_BYTE;
      word_timer_high_reload_q <= `RST_BYTE;
      irq_mask_q               <= `RST_BYTE;
      irq_edge_q               <= `RST_BYTE;
    end
    else if (wr_en && wr_ok && w_q.strb[0])
    begin
      unique case (wr_idx)
        `IDX_COMMON_CTRL: common_timer_control_q   <= wb;
        `IDX_BYTE_RLD_LO: byte_timer_low_reload_q  <= wb;
        `IDX_BYTE_RLD_HI: byte_timer_high_reload_q <= wb;
        `IDX_WORD_RLD_LO: word_timer_low_reload_q  <= wb;
        `IDX_WORD_RLD_HI: word_timer_high_reload_q <= wb;
        `IDX_IRQ_MASK:    irq_mask_q               <= wb;
        `IDX_IRQ_EDGE:    irq_edge_q               <= wb;
        default:          ;
      endcase
    end
  end

  // edge detection on measured input and comparator pins
  assign meas_in   = common_timer_control_q[`BIT_EDGE_SRC] ? port2_bit0_edge_input
                                                           : port3_comparator_input_a;
  assign meas_sel  = edge_sel_t'(common_timer_control_q[3:2]);
  assign cmp_sel   = edge_sel_t'(irq_edge_q[7:6]);
  assign meas_rise = meas_in && !meas_prev_q;
  assign meas_fall = !meas_in && meas_prev_q;
  assign meas_edge = (meas_rise && meas_sel[0]) || (meas_fall && meas_sel[1]);
  assign cmp_a_ev  = (cmp_sel[0] && port3_comparator_input_a && !cmp_a_prev_q)
                   || (cmp_sel[1] && !port3_comparator_input_a && cmp_a_prev_q);
  assign cmp_b_ev  = (cmp_sel[0] && port3_comparator_input_b && !cmp_b_prev_q)
                   || (cmp_sel[1] && !port3_comparator_input_b && cmp_b_prev_q);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meas_prev_q  <= 1'b0;
      cmp_a_prev_q <= 1'b0;
      cmp_b_prev_q <= 1'b0;
    end
    else
    begin
      meas_prev_q  <= meas_in;
      cmp_a_prev_q <= port3_comparator_input_a;
      cmp_b_prev_q <= port3_comparator_input_b;
    end
  end

  // byte timer prescaler, tick every 1, 2, 4 or 8 clocks
  always_comb
  begin
    unique case (byte_timer_control_q.prescale)
      2'b00: byte_tick = 1'b1;
      2'b01: byte_tick = div_q[0];
      2'b10: byte_tick = &div_q[1:0];
      2'b11: byte_tick = &div_q;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // byte timer events
  assign byte_to_ev  = byte_timer_control_q.run && byte_tick && !byte_stop_pend_q
                     && !common_timer_control_q[`BIT_BYTE_DEMOD] && (byte_cnt_q == `ZERO_8);
  assign byte_cap_ev = byte_timer_control_q.run && common_timer_control_q[`BIT_BYTE_DEMOD]
                     && byte_armed_q && meas_edge;

  // byte timer control register and counter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      byte_timer_control_q <= '0;
      byte_cnt_q           <= `ZERO_8;
      byte_out_q           <= 1'b0;
      byte_armed_q         <= 1'b0;
      byte_stop_pend_q     <= 1'b0;
      byte_clr_pend_q      <= 1'b0;
      // captures read back as zero until the first measurement lands
      byte_timer_capture_low_level_q  <= `ZERO_8;
      byte_timer_capture_high_level_q <= `ZERO_8;
    end
    else
    begin
      if (wr_en && wr_ok && w_q.strb[0] && wr_idx == `IDX_BYTE_CTRL)
      begin
        byte_timer_control_q.mode       <= wb[`BIT_MODE];
        byte_timer_control_q.prescale   <= wb[4:3];
        byte_timer_control_q.cap_int_en <= wb[`BIT_CAP_INT];
        byte_timer_control_q.out_en     <= wb[`BIT_OUT_EN];
        if (wb[`BIT_TIMEOUT])
          byte_clr_pend_q <= 1'b1;
        if (wb[`BIT_RUN] && !byte_timer_control_q.run)
        begin
          byte_timer_control_q.run <= 1'b1;
          byte_cnt_q               <= common_timer_control_q[`BIT_BYTE_DEMOD] ? `ALL_ONES_8
                                                                              : byte_timer_low_reload_q;
          byte_out_q               <= 1'b0;
          byte_armed_q             <= 1'b0;
          byte_stop_pend_q         <= 1'b0;
        end
        else if (!wb[`BIT_RUN] && byte_timer_control_q.run)
          byte_stop_pend_q <= 1'b1;
      end
      else if (byte_tick)
      begin
        // deferred stop and flag clear act one tick after the write
        if (byte_clr_pend_q)
        begin
          byte_clr_pend_q              <= 1'b0;
          byte_timer_control_q.timeout <= 1'b0;
        end
        if (byte_stop_pend_q)
        begin
          byte_stop_pend_q         <= 1'b0;
          byte_timer_control_q.run <= 1'b0;
        end
      end
      // counting, capture and time-out
      if (byte_cap_ev)
      begin
        if (meas_rise)
          byte_timer_capture_low_level_q <= ~byte_cnt_q;
        else
          byte_timer_capture_high_level_q <= ~byte_cnt_q;
        byte_cnt_q <= `ALL_ONES_8;
      end
      else if (byte_timer_control_q.run && common_timer_control_q[`BIT_BYTE_DEMOD] && meas_edge)
      begin
        byte_armed_q <= 1'b1;
        byte_cnt_q   <= `ALL_ONES_8;
      end
      else if (byte_to_ev)
      begin
        byte_out_q <= !byte_out_q;
        byte_cnt_q <= byte_out_q ? byte_timer_low_reload_q : byte_timer_high_reload_q;
        if (byte_timer_control_q.mode)
          byte_timer_control_q.run <= 1'b0;
      end
      else if (byte_timer_control_q.run && byte_tick && byte_armed_q)
        byte_cnt_q <= byte_cnt_q - 8'h01;
      else if (byte_timer_control_q.run && byte_tick && !common_timer_control_q[`BIT_BYTE_DEMOD])
        byte_cnt_q <= byte_cnt_q - 8'h01;
      // set wins over clear
      if (byte_to_ev)
        byte_timer_control_q.timeout <= 1'b1;
    end
  end

  // word timer, ticks every clock
  assign word_to_ev  = word_timer_control_q.run && !word_stop_pend_q
                     && !word_timer_control_q.mode && (word_cnt_q == `ZERO_16);
  assign word_cap_ev = word_timer_control_q.run && word_timer_control_q.mode
                     && word_armed_q && meas_edge;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_timer_control_q <= '0;
      word_cnt_q           <= `ZERO_16;
      word_out_q           <= 1'b0;
      word_armed_q         <= 1'b0;
      word_stop_pend_q     <= 1'b0;
      word_clr_pend_q      <= 1'b0;
      word_cap_q           <= `ZERO_16;
    end
    else
    begin
      if (wr_en && wr_ok && w_q.strb[0] && wr_idx == `IDX_WORD_CTRL)
      begin
        word_timer_control_q.mode       <= wb[`BIT_MODE];
        word_timer_control_q.cap_int_en <= wb[`BIT_CAP_INT];
        word_timer_control_q.out_en     <= wb[`BIT_OUT_EN];
        if (wb[`BIT_TIMEOUT])
          word_clr_pend_q <= 1'b1;
        if (wb[`BIT_RUN] && !word_timer_control_q.run)
        begin
          word_timer_control_q.run <= 1'b1;
          word_cnt_q               <= wb[`BIT_MODE] ? `ALL_ONES_16
                                                    : {word_timer_high_reload_q, word_timer_low_reload_q};
          word_out_q               <= 1'b0;
          word_armed_q             <= 1'b0;
          word_stop_pend_q         <= 1'b0;
        end
        else if (!wb[`BIT_RUN] && word_timer_control_q.run)
          word_stop_pend_q <= 1'b1;
      end
      else
      begin
        if (word_clr_pend_q)
        begin
          word_clr_pend_q              <= 1'b0;
          word_timer_control_q.timeout <= 1'b0;
        end
        if (word_stop_pend_q)
        begin
          word_stop_pend_q         <= 1'b0;
          word_timer_control_q.run <= 1'b0;
        end
      end
      if (word_cap_ev)
      begin
        word_cap_q <= ~word_cnt_q;
        word_cnt_q <= `ALL_ONES_16;
      end
      else if (word_timer_control_q.run && word_timer_control_q.mode && meas_edge)
      begin
        word_armed_q <= 1'b1;
        word_cnt_q   <= `ALL_ONES_16;
      end
      else if (word_to_ev)
      begin
        word_out_q <= !word_out_q;
        word_cnt_q <= {word_timer_high_reload_q, word_timer_low_reload_q};
      end
      else if (word_timer_control_q.run && (word_armed_q || !word_timer_control_q.mode))
        word_cnt_q <= word_cnt_q - 16'h0001;
      if (word_to_ev)
        word_timer_control_q.timeout <= 1'b1;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign ev_vec = {2'b00, cmp_b_ev, cmp_a_ev, word_cap_ev, word_to_ev, byte_cap_ev, byte_to_ev};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_status_q <= `RST_BYTE;
    else if (wr_en && wr_ok && w_q.strb[0] && wr_idx == `IDX_IRQ_STATUS)
      irq_status_q <= (irq_status_q & ~wb) | ev_vec;
    else
      irq_status_q <= irq_status_q | ev_vec;
  end

  // capture interrupts also gated by each timer's capture enable
  assign irq = |(irq_status_q & irq_mask_q
               & ~{4'h0, !word_timer_control_q.cap_int_en, 1'b0,
                   !byte_timer_control_q.cap_int_en, 1'b0});

  // port 3 timer outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port3_byte_timer_output     <= 1'b0;
      port3_word_timer_output     <= 1'b0;
      port3_combined_timer_output <= 1'b0;
    end
    else
    begin
      port3_byte_timer_output <= byte_timer_control_q.out_en && byte_out_q;
      port3_word_timer_output <= word_timer_control_q.out_en && word_out_q;
      unique case (comb_fn_t'(common_timer_control_q[5:4]))
        COMB_AND:  port3_combined_timer_output <= byte_out_q & word_out_q;
        COMB_OR:   port3_combined_timer_output <= byte_out_q | word_out_q;
        COMB_XOR:  port3_combined_timer_output <= byte_out_q ^ word_out_q;
        COMB_NAND: port3_combined_timer_output <= !(byte_out_q & word_out_q);
      endcase
    end
  end

endmodule : ir_counter_timer_capture

// >>> verilog/ir_timer_consts.svh
`ifndef IR_TIMER_CONSTS_SVH
`define IR_TIMER_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_BYTE_CTRL      4'h0
`define IDX_COMMON_CTRL    4'h1
`define IDX_WORD_CTRL      4'h2
`define IDX_BYTE_RLD_LO    4'h4
`define IDX_BYTE_RLD_HI    4'h5
`define IDX_WORD_RLD_LO    4'h6
`define IDX_WORD_RLD_HI    4'h7
`define IDX_WORD_CAP_LO    4'h8
`define IDX_WORD_CAP_HI    4'h9
`define IDX_BYTE_CAP_LO    4'ha
`define IDX_BYTE_CAP_HI    4'hb
`define IDX_IRQ_STATUS     4'hc
`define IDX_IRQ_MASK       4'hd
`define IDX_IRQ_EDGE       4'he

// control bit positions
`define BIT_RUN            7
`define BIT_MODE           6
`define BIT_TIMEOUT        5
`define BIT_CAP_INT        2
`define BIT_OUT_EN         0
`define BIT_EDGE_SRC       7
`define BIT_BYTE_DEMOD     6

// interrupt status bit positions
`define ST_BYTE_TO         0
`define ST_BYTE_CAP        1
`define ST_WORD_TO         2
`define ST_WORD_CAP        3
`define ST_CMP_A           4
`define ST_CMP_B           5

// reset values and fixed numbers
`define RST_BYTE           8'h00
`define ALL_ONES_8         8'hff
`define ALL_ONES_16        16'hffff
`define ZERO_8             8'h00
`define ZERO_16            16'h0000
`define RESP_OKAY          2'b00
`define RESP_DECERR        2'b11
`define ADDR_HI_ZERO       2'b00

`endif

// >>> verilog/ir_timer_pkg.sv
package ir_timer_pkg;

  // control register layout shared by both timers
  typedef struct packed {
    logic       run;
    logic       mode;
    logic       timeout;
    logic [1:0] prescale;
    logic       cap_int_en;
    logic       rsvd;
    logic       out_en;
  } timer_ctrl_t;

  // combined output function codes
  typedef enum logic [1:0] {
    COMB_AND  = 2'b00,
    COMB_OR   = 2'b01,
    COMB_XOR  = 2'b10,
    COMB_NAND = 2'b11
  } comb_fn_t;

  // edge selection codes
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  // read and write bus channels
  typedef struct packed {
    logic [7:0] addr;
  } axi_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } axi_wdata_t;

endpackage : ir_timer_pkg

// >>> sim/ir_timer_checker.sv
`timescale 1ns/10ps
module ir_timer_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  // one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  // both channels land in the holders first, the answer rises one cycle later
  AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write answer");
  AST_B_RELEASE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer stuck");
  AST_B_CODES: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b11) else $error("bad bresp");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  AST_R_RELEASE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during answer");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  AST_R_DECERR: assert property (s_axi_rvalid && s_axi_rresp == 2'b11 |-> s_axi_rdata == 32'h0)
    else $error("decode error with data");
endmodule : ir_timer_checker

bind ir_counter_timer_capture ir_timer_checker u_chk (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// >>> sim/ir_counter_timer_capture_tb_top.sv
`timescale 1ns/10ps
module ir_counter_timer_capture_tb_top;
  import ir_timer_pkg::*;
  logic        clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1;
  axi_addr_t   s_axi_aw = '0, s_axi_ar = '0;
  axi_wdata_t  s_axi_w = '0;
  logic        port3_comparator_input_a = 0, port3_comparator_input_b = 0, port2_bit0_edge_input = 0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic   port3_byte_timer_output, port3_word_timer_output, port3_combined_timer_output;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          n_mismatch = 0, check_count = 0, cyc = 0, n1, n2;
  logic [31:0] seed = 32'h0f7fe9e8, rv;
  logic [7:0]  mdl [16], h8, l8;
  logic [15:0] w1, w2;
  logic [1:0]  resp;

  ir_counter_timer_capture dut (.*);

  // free-running clock
  always #4 clk = ~clk;

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // register write, both channels offered together
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic ta, tw, na, nw;
    {ta, tw} = 2'b00;
    s_axi_aw <= '{addr: {2'b00, i, 2'b00}};
    s_axi_w <= '{data: {24'h0, d}, strb: 4'hf};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      na = s_axi_awvalid && s_axi_awready;
      nw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (na) s_axi_awvalid <= 1'b0;
      if (nw) s_axi_wvalid <= 1'b0;
      ta |= na;
      tw |= nw;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge clk);
  endtask : wr

  // register read
  task automatic rd(input logic [3:0] i);
    s_axi_ar <= '{addr: {2'b00, i, 2'b00}};
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk);
  endtask : rd

  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk(irq, e);
    @(posedge clk);
  endtask : ck_irq

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(0);
    chk(rv, 32'h0);
    for (int i = 4; i < 8; i++)
    begin
      mdl[i] = 8'(xs());
      wr(i, mdl[i]);
    end
    for (int i = 4; i < 8; i++)
    begin
      rd(i);
      chk(rv, mdl[i]);
    end
    rd(3);
    chk(rv, 32'h0);
    chk(resp, 2'b11);
    $display("reset and reload test done");
    for (int p = 0; p < 4; p++)
    begin
      wr(4, 8'h02);
      wr(0, 8'hc0 | p << 3);
      repeat (60) @(posedge clk);
      rd(0);
      chk(rv, 8'h60 | p << 3);
    end
    wr(0, 8'h61);
    repeat (4) @(posedge clk);
    rd(0);
    chk(rv, 32'h41);
    rd(12);
    chk(rv[0], 1);
    wr(13, 8'h01);
    ck_irq(1);
    wr(13, 8'h00);
    ck_irq(0);
    wr(13, 8'h01);
    wr(12, 8'hff);
    ck_irq(0);
    // byte toggle is high after its single pass, word toggle still low
    for (int c = 0; c < 4; c++)
    begin
      wr(1, 8'(c << 4));
      @(negedge clk);
      chk(port3_combined_timer_output, c != 0);
      chk({port3_byte_timer_output, port3_word_timer_output}, 2'b10);
      @(posedge clk);
    end
    $display("single pass and interrupt test done");
    for (int i = 4; i < 8; i++) wr(i, 8'hff);
    wr(1, 8'h4c);
    wr(2, 8'hc0);
    wr(0, 8'h80);
    wr(13, 8'h02);
    n1 = 300 + xs() % 40;
    n2 = 20 + xs() % 40;
    port3_comparator_input_a <= 1'b1;
    repeat (10) @(posedge clk);
    port3_comparator_input_a <= 1'b0;
    repeat (n2) @(posedge clk);
    port3_comparator_input_a <= 1'b1;
    fork
      repeat (n1) @(posedge clk);
      begin
        // let the capture of the rising edge land first
        repeat (2) @(posedge clk);
        rd(8);
        w1[7:0] = rv[7:0];
        rd(9);
        w1[15:8] = rv[7:0];
      end
    join
    port3_comparator_input_a <= 1'b0;
    repeat (10) @(posedge clk);
    rd(11);
    h8 = rv[7:0];
    rd(10);
    l8 = rv[7:0];
    chk(8'(h8 - l8), 8'(n1 - n2));
    rd(8);
    w2[7:0] = rv[7:0];
    rd(9);
    w2[15:8] = rv[7:0];
    chk(16'(w2 - w1), 16'(n1 - n2));
    rd(0);
    chk(rv[5], 0);
    ck_irq(0);
    wr(0, 8'h84);
    ck_irq(1);
    wr(10, xs());
    chk(resp, 2'b00);
    rd(10);
    chk(rv, l8);
    // same width pulse from the port 2 source must measure like the low gap
    wr(1, 8'hcc);
    port2_bit0_edge_input <= 1'b1;
    repeat (n2) @(posedge clk);
    port2_bit0_edge_input <= 1'b0;
    repeat (4) @(posedge clk);
    rd(11);
    chk(rv, l8);
    $display("capture test done");
    for (int e = 1; e < 4; e++)
    begin
      wr(12, 8'h30);
      wr(14, e << 6);
      port3_comparator_input_b <= 1'b1;
      repeat (6) @(posedge clk);
      rd(12);
      chk(rv[5], e[0]);
      wr(12, 8'h30);
      port3_comparator_input_b <= 1'b0;
      repeat (6) @(posedge clk);
      rd(12);
      chk(rv[5], e[1]);
    end
    $display("edge interrupt test done");
    stop_test();
  end
endmodule : ir_counter_timer_capture_tb_top
